// ---- core/otp_host_pkg.sv ----
// Constants and types shared by the OTP host sequencer
package otp_host_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          READ_WAIT_MS    = 15;
  localparam int          PROG_WAIT_MS    = 60;
  localparam int          READ_WAIT_CYC   = READ_WAIT_MS * (CLK_HZ / 1000);
  localparam int          PROG_WAIT_CYC   = PROG_WAIT_MS * (CLK_HZ / 1000);
  localparam int          SCCB_KHZ        = 100;
  localparam int          QUARTER_CYC     = CLK_HZ / (4 * SCCB_KHZ * 1000);
  localparam logic [8:0]  QUARTER_LAST    = 9'(QUARTER_CYC - 1);

  localparam logic [7:0]  SCCB_ID_WR      = 8'h60;
  localparam logic [7:0]  SCCB_ID_RD      = 8'h61;

  localparam logic [15:0] OTP_BUF_LOW     = 16'h3d00;
  localparam logic [15:0] OTP_CONTROL     = 16'h3d10;
  localparam logic [15:0] OTP_BUF_HIGH    = 16'h3d30;
  localparam int          BANK_BYTES      = 16;
  localparam int          OTP_BYTES       = 64;
  localparam logic [6:0]  LOW_COUNT       = 7'h10;
  localparam logic [6:0]  ALL_COUNT       = 7'h40;
  localparam logic [5:0]  TEMP_CAL_INDEX  = 6'h05;

  localparam logic [7:0]  CTRL_IDLE       = 8'h00;
  localparam logic [7:0]  CTRL_READ       = 8'h01;
  localparam logic [7:0]  CTRL_PROG       = 8'h02;
  localparam logic [7:0]  CTRL_ALL_BANKS  = 8'h10;

  typedef enum logic [1:0] {
    OP_READ     = 2'h0,
    OP_PROGRAM  = 2'h1,
    OP_VERIFY   = 2'h2,
    OP_TEMP_CAL = 2'h3
  } op_e;

  typedef struct packed {
    op_e        op;
    logic       all_banks;
    logic [7:0] cal_byte;
  } cmd_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic blank;
    logic match;
    logic err_not_blank;
    logic err_buffer;
  } status_s;
endpackage : otp_host_pkg

// ---- core/otp_host_sequencer.sv ----
// Host controller running the OTP read and program sequences over SCCB
// What this block does
// - Zero both buffer ranges before every read
// - Write control zero before the read command
// - Send read code, bank0 or all banks
// - Wait read time, then fetch both ranges
// - Read first and require blank array
// - Load intended bytes, zero unused buffer bytes only for temp cal
// - Read back low range, compare intended
// - Write control zero before program command
// - Send program code, bank0 or all banks
// - Wait program time with no access
// - Reread after programming and compare content
// - Offer verify command for final testing
// - Temperature calibration goes to byte index 5
`timescale 1ns/10ps
module otp_host_sequencer #(
  parameter int         READ_WAIT    = otp_host_pkg::READ_WAIT_CYC,
  parameter int         PROG_WAIT    = otp_host_pkg::PROG_WAIT_CYC,
  parameter logic [8:0] QUARTER_LAST = otp_host_pkg::QUARTER_LAST
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  cmd_valid_i,
  input  wire otp_host_pkg::cmd_s    cmd_i,
  input  wire logic                  load_we_i,
  input  wire logic [5:0]            load_idx_i,
  input  wire logic [7:0]            load_data_i,
  input  wire logic [5:0]            rd_idx_i,
  output logic      [7:0]            rd_data_o,
  output otp_host_pkg::status_s      status_o,
  output logic                       sio_c_o,
  output logic                       sio_d_o,
  output logic                       sio_d_oe_n_o,
  input  wire logic                  sio_d_i
);
  typedef enum logic [3:0] {
    E_IDLE  = 4'b0001,
    E_START = 4'b0010,
    E_BIT   = 4'b0100,
    E_STOP  = 4'b1000
  } eng_e;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_FILL  = 7'b0000010,
    S_CTL0  = 7'b0000100,
    S_GO    = 7'b0001000,
    S_WAIT  = 7'b0010000,
    S_FETCH = 7'b0100000,
    S_CHECK = 7'b1000000
  } seq_e;

  typedef enum logic [3:0] {
    PH_READ  = 4'b0001,
    PH_BLANK = 4'b0010,
    PH_LOAD  = 4'b0100,
    PH_CHECK = 4'b1000
  } ph_e;

  logic [7:0]  intended [otp_host_pkg::OTP_BYTES];
  logic [7:0]  readback [otp_host_pkg::OTP_BYTES];

  eng_e        eng;
  logic [8:0]  qcnt;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [2:0]  bi;
  logic [7:0]  shreg;
  logic [7:0]  rdata;
  logic        xdone;
  logic        sda_meta;
  logic        sda_sync;
  logic        next_scl;
  logic        next_sda;
  logic        next_oe_n;
  logic        tick;

  seq_e        st;
  ph_e         ph;
  otp_host_pkg::cmd_s cmd;
  logic        xreq;
  logic        xrnw;
  logic [15:0] xaddr;
  logic [7:0]  xwdat;
  logic [6:0]  idx;
  logic [20:0] wcnt;
  logic        nonzero;
  logic        mismatch;
  logic        burned;
  logic [7:0]  exp_byte;
  logic [15:0] buf_addr;
  logic [6:0]  fetch_count;

  function automatic logic [7:0] byte_val(input logic [2:0] b, input logic rnw,
                                          input logic [15:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    unique case (b)
      3'h0:    v = otp_host_pkg::SCCB_ID_WR;
      3'h1:    v = a[15:8];
      3'h2:    v = a[7:0];
      3'h3:    v = rnw ? otp_host_pkg::SCCB_ID_RD : d;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : byte_val

  assign tick = (qcnt == QUARTER_LAST);

  // Two-flop synchroniser for the data pin
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sio_d_i;
      sda_sync <= sda_meta;
    end
  end

  // Pin levels per quarter of each bit slot
  always_comb begin
    next_scl  = 1'b1;
    next_sda  = 1'b1;
    next_oe_n = 1'b0;
    unique case (eng)
      E_IDLE: begin
        next_scl = 1'b1;
      end
      E_START: begin
        next_scl = (q != 2'h3);
        next_sda = !q[1];
      end
      E_STOP: begin
        next_scl = (q != 2'h0);
        next_sda = q[1];
      end
      E_BIT: begin
        next_scl = q[1];
        if (bitn == 4'h8) begin
          next_oe_n = (bi != 3'h4);
        end else if (bi == 3'h4) begin
          next_oe_n = 1'b1;
        end else begin
          next_sda = shreg[7];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sio_c_o      <= 1'b1;
      sio_d_o      <= 1'b1;
      sio_d_oe_n_o <= 1'b1;
    end else begin
      sio_c_o      <= next_scl;
      sio_d_o      <= next_sda;
      sio_d_oe_n_o <= next_oe_n;
    end
  end

  // SCCB engine: 4-phase write, 3-phase write then 2-phase read
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      eng   <= E_IDLE;
      qcnt  <= 9'h000;
      q     <= 2'h0;
      bitn  <= 4'h0;
      bi    <= 3'h0;
      shreg <= 8'h00;
      rdata <= 8'h00;
      xdone <= 1'b0;
    end else begin
      xdone <= 1'b0;
      if (eng == E_IDLE) begin
        qcnt <= 9'h000;
        q    <= 2'h0;
        if (xreq && !xdone) begin
          eng <= E_START;
          bi  <= 3'h0;
        end
      end else begin
        qcnt <= tick ? 9'h000 : 9'(qcnt + 9'h001);
        if (tick) begin
          q <= 2'(q + 2'h1);
        end
        if (tick && q == 2'h2 && eng == E_BIT && bi == 3'h4 && bitn != 4'h8) begin
          rdata <= {rdata[6:0], sda_sync};
        end
        if (tick && q == 2'h3) begin
          unique case (eng)
            E_START: begin
              eng   <= E_BIT;
              bitn  <= 4'h0;
              shreg <= byte_val(bi, xrnw, xaddr, xwdat);
            end
            E_BIT: begin
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if ((!xrnw && bi == 3'h3) || (xrnw && bi == 3'h2) || bi == 3'h4) begin
                  eng <= E_STOP;
                end else begin
                  bi    <= 3'(bi + 3'h1);
                  shreg <= byte_val(3'(bi + 3'h1), xrnw, xaddr, xwdat);
                end
              end else begin
                bitn  <= 4'(bitn + 4'h1);
                shreg <= {shreg[6:0], 1'b0};
              end
            end
            E_STOP: begin
              if (xrnw && bi == 3'h2) begin
                bi  <= 3'h3;
                eng <= E_START;
              end else begin
                eng   <= E_IDLE;
                xdone <= 1'b1;
              end
            end
            default: eng <= E_IDLE;
          endcase
        end
      end
    end
  end

  // Buffer byte address and expected content for the current index
  always_comb begin
    if (idx < 7'(otp_host_pkg::BANK_BYTES)) begin
      buf_addr = otp_host_pkg::OTP_BUF_LOW + {10'h000, idx[5:0]};
    end else begin
      buf_addr = otp_host_pkg::OTP_BUF_HIGH + {10'h000, idx[5:0]} - 16'h0010;
    end
    if (cmd.op == otp_host_pkg::OP_TEMP_CAL) begin
      exp_byte = (idx[5:0] == otp_host_pkg::TEMP_CAL_INDEX) ? cmd.cal_byte : 8'h00;
    end else begin
      exp_byte = intended[idx[5:0]];
    end
    fetch_count = (ph == PH_LOAD) ? otp_host_pkg::LOW_COUNT : otp_host_pkg::ALL_COUNT;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!status_o.busy && load_we_i) begin
      intended[load_idx_i] <= load_data_i;
    end
    if (st == S_FETCH && xdone) begin
      readback[idx[5:0]] <= rdata;
    end
    rd_data_o <= readback[rd_idx_i];
  end

  // Operation sequencer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st       <= S_IDLE;
      ph       <= PH_READ;
      cmd      <= '0;
      xreq     <= 1'b0;
      xrnw     <= 1'b0;
      xaddr    <= 16'h0000;
      xwdat    <= 8'h00;
      idx      <= 7'h00;
      wcnt     <= 21'h000000;
      nonzero  <= 1'b0;
      mismatch <= 1'b0;
      burned   <= 1'b0;
      status_o <= '0;
    end else begin
      status_o.done <= 1'b0;
      unique case (st)
        S_IDLE: begin
          if (cmd_valid_i) begin
            cmd    <= cmd_i;
            idx    <= 7'h00;
            burned <= 1'b0;
            status_o <= '{busy: 1'b1, default: 1'b0};
            ph     <= (cmd_i.op == otp_host_pkg::OP_PROGRAM || cmd_i.op == otp_host_pkg::OP_TEMP_CAL)
                      ? PH_BLANK : PH_READ;
            st     <= S_FILL;
          end
        end
        S_FILL: begin
          if (!xreq) begin
            xreq  <= 1'b1;
            xrnw  <= 1'b0;
            xaddr <= buf_addr;
            xwdat <= (ph == PH_LOAD) ? exp_byte : 8'h00;
          end else if (xdone) begin
            xreq <= 1'b0;
            if (idx == otp_host_pkg::ALL_COUNT - 7'h01) begin
              idx      <= 7'h00;
              nonzero  <= 1'b0;
              mismatch <= 1'b0;
              st       <= (ph == PH_LOAD) ? S_FETCH : S_CTL0;
            end else begin
              idx <= 7'(idx + 7'h01);
            end
          end
        end
        S_CTL0: begin
          if (!xreq) begin
            xreq  <= 1'b1;
            xrnw  <= 1'b0;
            xaddr <= otp_host_pkg::OTP_CONTROL;
            xwdat <= otp_host_pkg::CTRL_IDLE;
          end else if (xdone) begin
            xreq <= 1'b0;
            st   <= S_GO;
          end
        end
        S_GO: begin
          if (!xreq) begin
            xreq  <= 1'b1;
            xrnw  <= 1'b0;
            xaddr <= otp_host_pkg::OTP_CONTROL;
            xwdat <= ((ph == PH_LOAD) ? otp_host_pkg::CTRL_PROG : otp_host_pkg::CTRL_READ)
                     | (cmd.all_banks ? otp_host_pkg::CTRL_ALL_BANKS : 8'h00);
          end else if (xdone) begin
            xreq <= 1'b0;
            wcnt <= 21'h000000;
            st   <= S_WAIT;
          end
        end
        S_WAIT: begin
          wcnt <= 21'(wcnt + 21'h000001);
          if (ph == PH_LOAD && wcnt == 21'(PROG_WAIT - 1)) begin
            burned <= 1'b1;
            ph     <= PH_CHECK;
            idx    <= 7'h00;
            st     <= S_FILL;
          end else if (ph != PH_LOAD && wcnt == 21'(READ_WAIT - 1)) begin
            idx      <= 7'h00;
            nonzero  <= 1'b0;
            mismatch <= 1'b0;
            st       <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (!xreq) begin
            xreq  <= 1'b1;
            xrnw  <= 1'b1;
            xaddr <= buf_addr;
          end else if (xdone) begin
            xreq <= 1'b0;
            if (rdata != 8'h00) begin
              nonzero <= 1'b1;
            end
            if (rdata != exp_byte) begin
              mismatch <= 1'b1;
            end
            if (idx == fetch_count - 7'h01) begin
              st <= S_CHECK;
            end else begin
              idx <= 7'(idx + 7'h01);
            end
          end
        end
        S_CHECK: begin
          idx <= 7'h00;
          if (ph == PH_BLANK && !nonzero) begin
            ph <= PH_LOAD;
            st <= S_FILL;
          end else if (ph == PH_LOAD && !mismatch) begin
            st <= S_CTL0;
          end else begin
            status_o.busy          <= 1'b0;
            status_o.done          <= 1'b1;
            status_o.blank         <= !nonzero;
            status_o.match         <= !mismatch;
            status_o.err_not_blank <= (ph == PH_BLANK);
            status_o.err_buffer    <= (ph == PH_LOAD);
            st                     <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule : otp_host_sequencer

// ---- verif/otp_host_asserts.sv ----
// Port assertions for the OTP host sequencer
`timescale 1ns/10ps
module otp_host_asserts #(
  parameter int READ_WAIT = 2000,
  parameter int PROG_WAIT = 4000
) (
  input wire logic                  clk_sys_i,
  input wire logic                  sys_rst_i,
  input wire logic                  cmd_valid_i,
  input wire otp_host_pkg::status_s status_o,
  input wire logic                  sio_c_o,
  input wire logic                  sio_d_o,
  input wire logic                  sio_d_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic        take;
  int unsigned hi_cnt;
  assign take = cmd_valid_i && !status_o.busy;
  // Length of the current clock-high stretch
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || take || !sio_c_o) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end
  property p_take; take |=> status_o.busy; endproperty
  a_take: assert property (p_take) else $error("busy not raised");
  property p_busy_end; $fell(status_o.busy) |-> status_o.done; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell without done");
  property p_done; status_o.done |-> !status_o.busy ##1 !status_o.done; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_idle; !status_o.busy |-> sio_c_o; endproperty
  a_idle: assert property (p_idle) else $error("bus active while idle");
  property p_gap; $fell(sio_c_o) && status_o.busy |-> hi_cnt < 1000 || hi_cnt >= READ_WAIT; endproperty
  a_gap: assert property (p_gap) else $error("wait too short");
  property p_hold;
    !status_o.busy && !take |=> $stable({status_o.blank, status_o.match, status_o.err_not_blank, status_o.err_buffer});
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed while idle");
  property p_err;
    status_o.done |-> (!status_o.err_not_blank || !status_o.blank) && (!status_o.err_buffer || !status_o.match);
  endproperty
  a_err: assert property (p_err) else $error("result flags contradict error");
  property p_start; sio_c_o && $past(sio_c_o) && !sio_d_oe_n_o && $fell(sio_d_o) |-> status_o.busy; endproperty
  a_start: assert property (p_start) else $error("start while idle");
  c_blank: cover property (status_o.done && status_o.blank);
  c_match: cover property (status_o.done && status_o.match);
  c_refuse: cover property (status_o.done && status_o.err_not_blank);
  c_prog: cover property ($fell(sio_c_o) && hi_cnt >= PROG_WAIT);
endmodule : otp_host_asserts
bind otp_host_sequencer otp_host_asserts #(.READ_WAIT(READ_WAIT), .PROG_WAIT(PROG_WAIT)) u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .status_o(status_o),
  .sio_c_o(sio_c_o), .sio_d_o(sio_d_o), .sio_d_oe_n_o(sio_d_oe_n_o));

// ---- verif/otp_dev_model.sv ----
// Behavioural OTP device on the serial control bus
`timescale 1ns/10ps
module otp_dev_model #(
  parameter int RD_NS = 60000,
  parameter int PG_NS = 150000
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_en_o,
  output logic      viol_o
);
  logic [7:0]  mem [64];
  logic [7:0]  bfr [64];
  logic [7:0]  dpc [64];
  logic [7:0]  ctrl, sr, dout;
  logic [15:0] ptr;
  logic        rd, busy;
  int          bitn, nb;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (bfr[i]) bfr[i] = 8'ha5;
    foreach (dpc[i]) dpc[i] = mem[i];
    {ctrl, sr, dout, ptr, rd, busy, sda_o, sda_en_o, viol_o} = '0;
    bitn = 0;
    nb = 9;
  end
  function automatic logic ok(input logic [15:0] a);
    return a[15:8] == 8'h3d && (a[7:4] == 4'h0 || (a[7:4] >= 4'h3 && a[7:4] <= 4'h5));
  endfunction : ok
  function automatic int ix(input logic [15:0] a);
    return (a < 16'h3d10) ? int'(a - 16'h3d00) : int'(a - 16'h3d30) + 16;
  endfunction : ix
  task automatic burn(input logic [7:0] b);
    busy = 1'b1;
    #(b[1] ? PG_NS : RD_NS);
    for (int i = 0; i < (b[5:4] != 2'h0 ? 64 : 16); i++) begin
      if (b[1]) mem[i] = mem[i] | bfr[i];
      else bfr[i] = mem[i];
    end
    busy = 1'b0;
  endtask : burn
  task automatic wr(input logic [7:0] b);
    if (ptr == 16'h3d10) begin
      if (!busy) begin
        if (b[1:0] != 2'h0 && ctrl != 8'h00) viol_o = 1'b1;
        if (b[1:0] == 2'h1) foreach (bfr[i]) if (bfr[i] != 8'h00) viol_o = 1'b1;
        ctrl = b;
        if (b[1:0] != 2'h0) fork burn(b); join_none
      end
    end else if (ok(ptr)) bfr[ix(ptr)] = b;
  endtask : wr
  // Start and stop, checked once the clock had a chance to move
  always @(negedge sda_i) begin
    #1;
    if (scl_i === 1'b1 && sda_i === 1'b0) begin
      bitn = 0;
      nb = 0;
      rd = 1'b0;
      if (busy && ctrl[1]) viol_o = 1'b1;
    end
  end
  always @(posedge sda_i) begin
    #1;
    if (scl_i === 1'b1 && sda_i === 1'b1) nb = 9;
  end
  always @(posedge scl_i) begin
    if (bitn < 8) sr = {sr[6:0], sda_i};
    if (bitn == 7 && nb < 4) begin
      if (nb == 0) begin
        rd = sr[0];
        dout = (ptr == 16'h3d10) ? ctrl : ok(ptr) ? bfr[ix(ptr)] : 8'h00;
      end else if (!rd && nb == 1) ptr[15:8] = sr;
      else if (!rd && nb == 2) ptr[7:0] = sr;
      else if (!rd && nb == 3) wr(sr);
      nb++;
    end
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // Acknowledge low, read data bits, otherwise released to the pull-up
  always @(negedge scl_i) begin
    sda_en_o = (bitn == 8 && nb < 9 && !(rd && nb == 2)) || (rd && nb == 1 && bitn < 8);
    sda_o = (bitn == 8) ? 1'b0 : dout[3'(7 - bitn)];
  end
endmodule : otp_dev_model

// ---- verif/otp_read_program_sequencer_tb_top.sv ----
// Top testbench for the OTP host sequencer
`timescale 1ns/10ps
module otp_read_program_sequencer_tb_top;
  logic                  clk_sys_i, sys_rst_i, cmd_valid_i, load_we_i;
  logic                  sio_c_o, sio_d_o, sio_d_oe_n_o, sda, sdv, den, viol;
  logic [5:0]            load_idx_i, rd_idx_i;
  logic [7:0]            load_data_i, rd_data_o;
  otp_host_pkg::cmd_s    cmd_i;
  otp_host_pkg::status_s status_o;
  int                    miscompares, check_count;
  assign sda = (sio_d_oe_n_o ? 1'b1 : sio_d_o) & (den ? sdv : 1'b1);
  otp_host_sequencer #(.READ_WAIT(2000), .PROG_WAIT(4000), .QUARTER_LAST(9'h001)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .load_we_i(load_we_i), .load_idx_i(load_idx_i), .load_data_i(load_data_i), .rd_idx_i(rd_idx_i),
    .rd_data_o(rd_data_o), .status_o(status_o), .sio_c_o(sio_c_o), .sio_d_o(sio_d_o),
    .sio_d_oe_n_o(sio_d_oe_n_o), .sio_d_i(sda));
  otp_dev_model dev (.scl_i(sio_c_o), .sda_i(sda), .sda_o(sdv), .sda_en_o(den), .viol_o(viol));
  task automatic cmp_st(input otp_host_pkg::status_s got, input otp_host_pkg::status_s exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_st
  task automatic cmp_b(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_b
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic load(input logic [7:0] k);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys_i);
      load_we_i <= 1'b1;
      load_idx_i <= 6'(i);
      load_data_i <= 8'(i) * k + k;
    end
    @(posedge clk_sys_i);
    load_we_i <= 1'b0;
  endtask : load
  // Issue a command, poke it again while busy, then await completion
  task automatic run(input otp_host_pkg::op_e o, input logic a, input logic [3:0] e);
    @(posedge clk_sys_i);
    cmd_i <= '{op: o, all_banks: a, cal_byte: 8'h5a};
    cmd_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    load_we_i <= 1'b1;
    load_data_i <= 8'hff;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    load_we_i <= 1'b0;
    for (int n = 0; n < 200000 && status_o.done !== 1'b1; n++) @(negedge clk_sys_i);
    cmp_st(status_o, {2'b01, e});
  endtask : run
  task automatic chk(input logic [7:0] k);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys_i);
      rd_idx_i <= 6'(i);
      repeat (2) @(negedge clk_sys_i);
      cmp_b(rd_data_o, 8'(i) * k + k);
      cmp_b(dev.mem[i], 8'(i) * k + k);
    end
  endtask : chk
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    // Four operations of roughly 50k to 130k cycles each
    repeat (400000) @(posedge clk_sys_i);
    miscompares++;
    end_sim();
  end
  initial begin
    {sys_rst_i, cmd_valid_i, load_we_i, load_idx_i, load_data_i, rd_idx_i} = 23'h400000;
    cmd_i = '0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cmp_b(dev.dpc[5], 8'h00);
    load(8'h00);
    run(otp_host_pkg::OP_READ, 1'b0, 4'b1100);
    load(8'h03);
    run(otp_host_pkg::OP_PROGRAM, 1'b1, 4'b0100);
    run(otp_host_pkg::OP_VERIFY, 1'b1, 4'b0100);
    chk(8'h03);
    run(otp_host_pkg::OP_TEMP_CAL, 1'b1, 4'b0010);
    chk(8'h03);
    cmp_b({7'h00, viol}, 8'h00);
    end_sim();
  end
endmodule : otp_read_program_sequencer_tb_top
